// file: verilog/cache_data_memory_control.sv
`timescale 1ns/1ns
module cache_data_memory_control (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic two_way_cfg_i,
    input wire logic flush_i,
    input wire logic cpu_ads_n_i,
    input wire logic cpu_mio_i,
    input wire logic cpu_wr_i,
    input wire logic [31:2] cpu_addr_i,
    input wire logic [3:0] cpu_be_n_i,
    input wire logic local_bus_access_n_i,
    input wire logic noncacheable_access_n_i,
    input wire logic half_width_access_n_i,
    input wire logic local_ready_n_i,
    output logic cpu_ready_n_o,
    output logic sys_ads_n_o,
    output logic sys_mio_o,
    output logic sys_wr_o,
    output logic [31:2] sys_addr_o,
    output logic [3:0] sys_be_n_o,
    input wire logic bus_ready_n_i,
    output logic cache_address_latch_enable_o,
    output logic [12:0] cache_sram_addr_o,
    output logic [1:0] cache_sram_cs_n_o,
    output logic [1:0] cache_sram_output_enable_n_o,
    output logic [1:0] cache_sram_write_strobe_n_o,
    output logic data_buf_dir_o,
    output logic data_buf_en_n_o
);
    typedef enum {
        ST_IDLE,
        ST_HIT,
        ST_HIT_END,
        ST_SYS_START,
        ST_SYS_WAIT,
        ST_WAIT_LOCAL
    } state_t;

    localparam int IW = cache_ctrl_pkg::IDX_W;
    localparam int TW = cache_ctrl_pkg::TAG_W;

    state_t state;
    state_t next_state;
    logic [1:0] flush_meta;
    logic [1:0] flush_sync;
    logic [1:0] cfg_meta;
    logic [1:0] cfg_sync;
    logic fill_req;
    logic way;
    logic sram_on;
    logic rd_on;
    logic wr_on;

    tag_dir_if dir_bus ();

    tag_directory directory (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .dir(dir_bus)
    );

    // sram location of an address; two-way leaves the top bit clear
    function automatic logic [IW-1:0] sram_index(input logic two_way,
                                                 input logic [31:2] a);
        if (two_way) begin
            sram_index = {1'h0,
                a[cache_ctrl_pkg::TW_IDX_MSB:2]};
        end else begin
            sram_index = a[cache_ctrl_pkg::DM_IDX_MSB:2];
        end
    endfunction

    // bit 20 sits inside the tag, so it must already be gated outside
    function automatic logic [TW-1:0] dir_tag(input logic two_way,
                                              input logic [31:2] a);
        if (two_way) begin
            dir_tag = a[31:cache_ctrl_pkg::TW_TAG_LSB];
        end else begin
            dir_tag = {1'h0, a[31:cache_ctrl_pkg::DM_TAG_LSB]};
        end
    endfunction

    // flush and strap are pins, not bus signals; the bus runs on this clock
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flush_meta <= 2'h0;
            flush_sync <= 2'h0;
        end else begin
            flush_meta <= {flush_meta[0], flush_i};
            flush_sync <= {flush_sync[0], flush_meta[1]};
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_meta <= 2'h0;
            cfg_sync <= 2'h0;
        end else begin
            cfg_meta <= {cfg_meta[0], two_way_cfg_i};
            cfg_sync <= {cfg_sync[0], cfg_meta[1]};
        end
    end

    wire flush = flush_sync[1];
    wire two_way = cfg_sync[1];

    // request decode, evaluated against the live local bus
    wire start = state == ST_IDLE && !cpu_ads_n_i;
    wire is_coproc = !cpu_mio_i && cpu_addr_i[cache_ctrl_pkg::COPROC_BIT];
    wire is_local = !local_bus_access_n_i;
    wire bypass = is_coproc | is_local;
    // held flush keeps the directory busy, which forces every miss
    wire cacheable = cpu_mio_i && noncacheable_access_n_i
        && half_width_access_n_i
        && !dir_bus.busy;
    wire rd_hit = cacheable && !cpu_wr_i && dir_bus.hit;
    wire miss_fill = cacheable && !cpu_wr_i && !dir_bus.hit;
    wire write_upd = cacheable && cpu_wr_i && dir_bus.hit;
    wire go_hit = start && !bypass && rd_hit;
    wire go_sys = start && !bypass && !rd_hit;
    wire go_upd = go_sys && (miss_fill || write_upd);
    // a miss replaces the way not used last; direct mode only has way 0
    wire pick_way = dir_bus.hit ? dir_bus.hit_way : dir_bus.victim;
    wire sys_done = state == ST_SYS_WAIT && !bus_ready_n_i;
    wire done = state == ST_HIT_END || sys_done;

    assign dir_bus.two_way = two_way;
    assign dir_bus.idx = sram_index(two_way, cpu_addr_i);
    assign dir_bus.tag = dir_tag(two_way, cpu_addr_i);
    assign dir_bus.touch = start && !bypass && cacheable && dir_bus.hit;
    assign dir_bus.flush = flush;
    // a flush during the miss leaves the line invalid but harmless
    assign dir_bus.fill = sys_done && fill_req
        && !dir_bus.busy;
    assign dir_bus.fill_way = way;
    assign dir_bus.fill_idx = sram_index(two_way, sys_addr_o);
    assign dir_bus.fill_tag = dir_tag(two_way, sys_addr_o);

    // one request in flight; ads outside idle is ignored
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start && bypass) begin
                    next_state = ST_WAIT_LOCAL;
                end else if (go_hit) begin
                    next_state = ST_HIT;
                end else if (go_sys) begin
                    next_state = ST_SYS_START;
                end
            end
            ST_HIT: begin
                next_state = ST_HIT_END;
            end
            ST_HIT_END: begin
                next_state = ST_IDLE;
            end
            ST_SYS_START: begin
                next_state = ST_SYS_WAIT;
            end
            ST_SYS_WAIT: begin
                if (!bus_ready_n_i) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WAIT_LOCAL: begin
                if (!local_ready_n_i) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // sram activity flags, built one step ahead so strobes come from flops
    wire next_sram_on = go_hit || go_upd || (sram_on && !done);
    wire next_rd_on = go_hit || (rd_on && !done);
    wire next_wr_on = go_upd || (wr_on && !done);
    wire next_way = start ? pick_way : way;
    wire [1:0] next_cs_n;
    wire [1:0] next_oe_n;
    wire [1:0] next_we_n;

    genvar w;
    generate
        for (w = 0; w < 2; w++) begin : g_bank
            wire sel = next_way == w;
            assign next_cs_n[w] = !(next_sram_on && sel);
            assign next_oe_n[w] = !(next_rd_on && sel);
            // strobe ends at the edge that samples system ready
            assign next_we_n[w] = !(next_wr_on && sel);
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sram_on <= 1'h0;
            rd_on <= 1'h0;
            wr_on <= 1'h0;
            way <= 1'h0;
            fill_req <= 1'h0;
        end else begin
            sram_on <= next_sram_on;
            rd_on <= next_rd_on;
            wr_on <= next_wr_on;
            way <= next_way;
            fill_req <= start ? (go_sys && miss_fill) : fill_req;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cache_sram_cs_n_o <= cache_ctrl_pkg::BANK_IDLE_N;
            cache_sram_output_enable_n_o <= cache_ctrl_pkg::BANK_IDLE_N;
            cache_sram_write_strobe_n_o <= cache_ctrl_pkg::BANK_IDLE_N;
        end else begin
            cache_sram_cs_n_o <= next_cs_n;
            cache_sram_output_enable_n_o <= next_oe_n;
            cache_sram_write_strobe_n_o <= next_we_n;
        end
    end

    // buffers face the cpu only while the sram is being read
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_buf_en_n_o <= cache_ctrl_pkg::STROBE_IDLE_N;
            data_buf_dir_o <= 1'h0;
        end else begin
            data_buf_en_n_o <= !next_sram_on;
            data_buf_dir_o <= next_rd_on;
        end
    end

    // latch opens for one cycle at the start, then the index stays put
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cache_address_latch_enable_o <= 1'h0;
            cache_sram_addr_o <= cache_ctrl_pkg::SRAM_ADDR_RST;
        end else begin
            cache_address_latch_enable_o <= start;
            if (start) begin
                cache_sram_addr_o <=
                    sram_index(two_way, cpu_addr_i);
            end
        end
    end

    // system side mirrors the local bus: address phase, strobe, ready
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sys_addr_o <= cache_ctrl_pkg::BUS_ADDR_RST;
            sys_be_n_o <= cache_ctrl_pkg::BE_IDLE_N;
            sys_mio_o <= 1'h0;
            sys_wr_o <= 1'h0;
        end else if (start) begin
            sys_addr_o <= cpu_addr_i;
            sys_be_n_o <= cpu_be_n_i;
            sys_mio_o <= cpu_mio_i;
            sys_wr_o <= cpu_wr_i;
        end
    end

    assign sys_ads_n_o = state != ST_SYS_START;

    // a miss returns to the cpu on the system ready itself
    always_comb begin
        case (state)
            ST_HIT_END: cpu_ready_n_o = 1'h0;
            ST_SYS_WAIT: cpu_ready_n_o = bus_ready_n_i;
            default: cpu_ready_n_o = cache_ctrl_pkg::STROBE_IDLE_N;
        endcase
    end
endmodule

// file: pkg/cache_ctrl_pkg.sv
package cache_ctrl_pkg;
    // external data memory geometry
    localparam int DM_ENTRIES = 8192;
    localparam int WAY_SETS = 4096;
    localparam int IDX_W = 13;
    localparam int SET_W = 12;
    localparam int TAG_W = 18;
    // address field positions
    localparam int IDX_LSB = 2;
    localparam int DM_IDX_MSB = 14;
    localparam int TW_IDX_MSB = 13;
    localparam int DM_TAG_LSB = 15;
    localparam int TW_TAG_LSB = 14;
    localparam int COPROC_BIT = 31;
    // values after reset, and the last sweep entry
    localparam logic STROBE_IDLE_N = 1'h1;
    localparam logic [1:0] BANK_IDLE_N = 2'h3;
    localparam logic [IDX_W-1:0] SRAM_ADDR_RST = 13'h0000;
    localparam logic [29:0] BUS_ADDR_RST = 30'h0000_0000;
    localparam logic [3:0] BE_IDLE_N = 4'hf;
    localparam logic [IDX_W-1:0] SWEEP_RST = 13'h0000;
    localparam logic [IDX_W-1:0] SWEEP_LAST = 13'h1fff;
endpackage

// file: pkg/tag_dir_if.sv
`timescale 1ns/1ns
interface tag_dir_if;
    logic two_way;
    logic [cache_ctrl_pkg::IDX_W-1:0] idx;
    logic [cache_ctrl_pkg::TAG_W-1:0] tag;
    logic hit;
    logic hit_way;
    logic victim;
    logic touch;
    logic fill;
    logic fill_way;
    logic [cache_ctrl_pkg::IDX_W-1:0] fill_idx;
    logic [cache_ctrl_pkg::TAG_W-1:0] fill_tag;
    logic flush;
    logic busy;
    modport ctrl (
        output two_way, idx, tag, touch, fill, fill_way, fill_idx,
        output fill_tag, flush,
        input hit, hit_way, victim, busy
    );
    modport dir (
        input two_way, idx, tag, touch, fill, fill_way, fill_idx,
        input fill_tag, flush,
        output hit, hit_way, victim, busy
    );
endinterface

// file: verilog/tag_directory.sv
`timescale 1ns/1ns
module tag_directory (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    tag_dir_if.dir dir
);
    localparam int IW = cache_ctrl_pkg::IDX_W;
    localparam int SW = cache_ctrl_pkg::SET_W;

    logic [cache_ctrl_pkg::TAG_W-1:0] tag_mem [0:cache_ctrl_pkg::DM_ENTRIES-1];
    logic valid_mem [0:cache_ctrl_pkg::DM_ENTRIES-1];
    logic lru [0:cache_ctrl_pkg::WAY_SETS-1];
    logic [IW-1:0] sweep;
    logic sweeping;

    // in two-way mode the way picks the upper half of the entry space
    function automatic logic [IW-1:0] entry(input logic two_way,
                                            input logic way,
                                            input logic [IW-1:0] idx);
        entry = two_way ? {way, idx[SW-1:0]} : idx;
    endfunction

    wire [IW-1:0] e0 = entry(dir.two_way, 1'h0, dir.idx);
    wire [IW-1:0] e1 = entry(1'h1, 1'h1, dir.idx);
    wire [IW-1:0] ef = entry(dir.two_way, dir.fill_way, dir.fill_idx);
    wire match0 = valid_mem[e0] && tag_mem[e0] == dir.tag;
    wire match1 = dir.two_way && valid_mem[e1] && tag_mem[e1] == dir.tag;

    // a sweep in progress reports misses so nothing stale is served
    assign dir.busy = sweeping | dir.flush;
    assign dir.hit = ~dir.busy & (match0 | match1);
    assign dir.hit_way = match1;
    assign dir.victim = dir.two_way & ~lru[dir.idx[SW-1:0]];

    // reset starts a sweep too, since the arrays themselves hold no reset
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sweeping <= 1'h1;
            sweep <= cache_ctrl_pkg::SWEEP_RST;
        end else if (dir.flush) begin
            sweeping <= 1'h1;
            sweep <= cache_ctrl_pkg::SWEEP_RST;
        end else if (sweeping) begin
            sweeping <= sweep != cache_ctrl_pkg::SWEEP_LAST;
            sweep <= sweep + 13'h0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (dir.busy) begin
            valid_mem[sweep] <= 1'h0;
        end else if (dir.fill) begin
            valid_mem[ef] <= 1'h1;
            tag_mem[ef] <= dir.fill_tag;
        end
    end

    // the sweep clears the way history too, so a victim is never unknown
    always_ff @(posedge ref_clk_i) begin
        if (dir.busy) begin
            lru[sweep[SW-1:0]] <= 1'h0;
        end else if (dir.two_way && dir.fill) begin
            lru[dir.fill_idx[SW-1:0]] <= dir.fill_way;
        end else if (dir.two_way && dir.touch) begin
            lru[dir.idx[SW-1:0]] <= dir.hit_way;
        end
    end
endmodule

// file: test/cache_ctrl_monitor.sv
`timescale 1ns/1ns
module cache_ctrl_monitor (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic two_way_cfg_i,
    input wire logic cpu_ads_n_i,
    input wire logic cpu_mio_i,
    input wire logic [31:2] cpu_addr_i,
    input wire logic local_bus_access_n_i,
    input wire logic cpu_ready_n_o,
    input wire logic sys_ads_n_o,
    input wire logic bus_ready_n_i,
    input wire logic cache_address_latch_enable_o,
    input wire logic [12:0] cache_sram_addr_o,
    input wire logic [1:0] cache_sram_cs_n_o,
    input wire logic [1:0] cache_sram_output_enable_n_o,
    input wire logic [1:0] cache_sram_write_strobe_n_o,
    input wire logic data_buf_dir_o,
    input wire logic data_buf_en_n_o
);
    wire logic ale = cache_address_latch_enable_o;
    wire logic cs_on = cache_sram_cs_n_o != 2'h3;
    wire logic oe_on = cache_sram_output_enable_n_o != 2'h3;
    wire logic we_on = cache_sram_write_strobe_n_o != 2'h3;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_fill_end;
        we_on && !bus_ready_n_i;
    endsequence
    ale_after_ads_a: assert property (
        ale |-> $past(cpu_ads_n_i) == 1'b0) else $error("latch without strobe");
    addr_hold_a: assert property (
        cs_on && $past(cs_on) |-> $stable(cache_sram_addr_o))
        else $error("sram address moved during access");
    direct_index_a: assert property (
        ale && !two_way_cfg_i |-> cache_sram_addr_o == $past(cpu_addr_i[14:2]))
        else $error("direct index wrong");
    way_index_a: assert property (
        ale && two_way_cfg_i
        |-> cache_sram_addr_o == {1'b0, $past(cpu_addr_i[13:2])})
        else $error("way index wrong");
    direct_bank_a: assert property (
        !two_way_cfg_i |-> cache_sram_cs_n_o[1]) else $error("bank 1 in direct");
    strobe_end_a: assert property (
        s_fill_end |=> !we_on) else $error("strobe held past ready");
    strobe_rise_a: assert property (
        $fell(we_on) |-> $past(bus_ready_n_i) == 1'b0)
        else $error("strobe rose without ready");
    hit_ready_a: assert property (
        !cpu_ready_n_o && bus_ready_n_i |-> $past(cpu_ads_n_i, 2) == 1'b0)
        else $error("hit ready not in cycle 2");
    hit_no_sys_a: assert property (
        oe_on |-> sys_ads_n_o) else $error("system cycle on read hit");
    local_no_sys_a: assert property (
        !sys_ads_n_o |-> $past(local_bus_access_n_i))
        else $error("local cycle forwarded");
    coproc_idle_a: assert property (
        !sys_ads_n_o |-> $past(cpu_mio_i) || !$past(cpu_addr_i[31]))
        else $error("coprocessor cycle forwarded");
    buf_read_a: assert property (
        oe_on |-> data_buf_dir_o && !data_buf_en_n_o)
        else $error("buffer not toward cpu");
endmodule
bind cache_data_memory_control cache_ctrl_monitor u_mon (
    .ref_clk_i, .nrst_i, .two_way_cfg_i, .cpu_ads_n_i, .cpu_mio_i,
    .cpu_addr_i, .local_bus_access_n_i, .cpu_ready_n_o, .sys_ads_n_o,
    .bus_ready_n_i, .cache_address_latch_enable_o, .cache_sram_addr_o,
    .cache_sram_cs_n_o, .cache_sram_output_enable_n_o,
    .cache_sram_write_strobe_n_o, .data_buf_dir_o, .data_buf_en_n_o
);

// file: test/bus_partner_model.sv
`timescale 1ns/1ns
module bus_partner_model (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] wait_i,
    input wire logic sys_ads_n_i,
    input wire logic cpu_ads_n_i,
    input wire logic cpu_mio_i,
    input wire logic cpu_a31_i,
    input wire logic local_bus_access_n_i,
    output logic bus_ready_n_o,
    output logic local_ready_n_o
);
    logic bus_busy;
    logic loc_busy;
    logic [3:0] bus_cnt;
    logic [3:0] loc_cnt;
    // local devices and the coprocessor end their own cycles
    wire logic loc_start = !cpu_ads_n_i
        && (!local_bus_access_n_i || (!cpu_mio_i && cpu_a31_i));
    assign bus_ready_n_o = !(bus_busy && bus_cnt == 4'h0);
    assign local_ready_n_o = !(loc_busy && loc_cnt == 4'h0);
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_busy <= 1'b0;
            loc_busy <= 1'b0;
            bus_cnt <= 4'h0;
            loc_cnt <= 4'h0;
        end else begin
            if (!sys_ads_n_i) begin
                bus_busy <= 1'b1;
                bus_cnt <= wait_i;
            end else if (bus_busy) begin
                bus_busy <= bus_cnt != 4'h0;
                bus_cnt <= bus_cnt - {3'h0, bus_cnt != 4'h0};
            end
            if (loc_start) begin
                loc_busy <= 1'b1;
                loc_cnt <= 4'h2;
            end else if (loc_busy) begin
                loc_busy <= loc_cnt != 4'h0;
                loc_cnt <= loc_cnt - {3'h0, loc_cnt != 4'h0};
            end
        end
    end
endmodule

// file: test/test_cache_data_memory_control.sv
`timescale 1ns/1ns
module test_cache_data_memory_control;
    // bit twenty low
    localparam logic [31:2] addr_a = 30'h0000_1234;
    localparam logic [31:2] addr_d = 30'h0000_3234;
    localparam logic [31:2] addr_b = 30'h0000_0567;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cfg = 1'b0;
    logic flush = 1'b0;
    logic ads_n = 1'b1;
    logic mio = 1'b1;
    logic wr = 1'b0;
    logic [31:2] addr = 30'h0000_0000;
    logic lba_n = 1'b1;
    logic nca_n = 1'b1;
    logic x16_n = 1'b1;
    logic [3:0] wt = 4'h0;
    logic bus_rdy_n, loc_rdy_n, cpu_rdy_n, sys_ads_n, ale;
    logic [12:0] sram_addr, sa, rc;
    logic [31:2] sys_addr;
    logic sys_wr;
    logic [1:0] oe_n, we_n;
    logic saw_sys, saw_we, saw_oe, we_rdy;
    int num_errors = 0;
    int n_tests = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    cache_data_memory_control u_dut (
        .ref_clk_i, .nrst_i, .two_way_cfg_i(cfg), .flush_i(flush),
        .cpu_ads_n_i(ads_n), .cpu_mio_i(mio), .cpu_wr_i(wr),
        .cpu_addr_i(addr), .cpu_be_n_i(4'h0), .local_bus_access_n_i(lba_n),
        .noncacheable_access_n_i(nca_n), .half_width_access_n_i(x16_n),
        .local_ready_n_i(loc_rdy_n), .cpu_ready_n_o(cpu_rdy_n),
        .sys_ads_n_o(sys_ads_n), .sys_mio_o(), .sys_wr_o(sys_wr),
        .sys_addr_o(sys_addr), .sys_be_n_o(), .bus_ready_n_i(bus_rdy_n),
        .cache_address_latch_enable_o(ale), .cache_sram_addr_o(sram_addr),
        .cache_sram_cs_n_o(), .cache_sram_output_enable_n_o(oe_n),
        .cache_sram_write_strobe_n_o(we_n), .data_buf_dir_o(),
        .data_buf_en_n_o()
    );
    bus_partner_model u_far (
        .ref_clk_i, .nrst_i, .wait_i(wt), .sys_ads_n_i(sys_ads_n),
        .cpu_ads_n_i(ads_n), .cpu_mio_i(mio), .cpu_a31_i(addr[31]),
        .local_bus_access_n_i(lba_n), .bus_ready_n_o(bus_rdy_n),
        .local_ready_n_o(loc_rdy_n)
    );
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_bit(input string what, input logic exp, got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_val(input string what, input logic [12:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_addr(input string what, input logic [31:2] exp, got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic access(input logic [31:2] a, input logic l, m, n, x);
        int c;
        addr = a;
        lba_n = l;
        mio = m;
        nca_n = n;
        x16_n = x;
        ads_n = 1'b0;
        {saw_sys, saw_we, saw_oe, we_rdy} = 4'h0;
        rc = 13'h0000;
        sa = 13'h1fff;
        @(negedge ref_clk_i);
        ads_n = 1'b1;
        for (c = 1; c < 40; c++) begin
            saw_sys |= sys_ads_n === 1'b0;
            saw_we |= we_n !== 2'h3;
            saw_oe |= oe_n !== 2'h3;
            if (ale === 1'b1) sa = sram_addr;
            if (cpu_rdy_n === 1'b0) begin
                rc = c[12:0];
                we_rdy = we_n !== 2'h3;
            end
            if (cpu_rdy_n === 1'b0 || loc_rdy_n === 1'b0) break;
            @(negedge ref_clk_i);
        end
        if (c == 40) begin
            num_errors++;
            $display("unexpected ready: expected 0 seen 1");
            final_report();
        end
        @(negedge ref_clk_i);
    endtask
    task automatic expect_miss(input logic [12:0] idx);
        chk_bit("system cycle", 1'b1, saw_sys);
        chk_bit("strobe at ready", 1'b1, we_rdy);
        chk_val("ready cycle", 13'h0002 + {9'h000, wt}, rc);
        chk_val("sram index", idx, sa);
        chk_addr("system address", addr, sys_addr);
        chk_bit("system write", wr, sys_wr);
    endtask
    task automatic expect_hit(input logic [12:0] idx);
        chk_bit("system cycle", 1'b0, saw_sys);
        chk_bit("output enable", 1'b1, saw_oe);
        chk_val("ready cycle", 13'h0002, rc);
        chk_val("sram index", idx, sa);
    endtask
    task automatic expect_pass(input logic sys, input logic [12:0] cyc);
        chk_bit("system cycle", sys, saw_sys);
        chk_bit("strobe", 1'b0, saw_we);
        chk_bit("output enable", 1'b0, saw_oe);
        chk_val("ready cycle", cyc, rc);
    endtask
    task automatic s_direct;
        wt = 4'h3;
        access(addr_a, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_miss(13'h1234);
        wt = 4'h0;
        access(addr_a, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_hit(13'h1234);
        // write hit strobes the sram, write miss leaves it alone
        wr = 1'b1;
        access(addr_a, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_miss(13'h1234);
        access(addr_d, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_pass(1'b1, 13'h0002);
        wr = 1'b0;
        access(addr_d, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_miss(13'h1234);
        access(addr_a, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_miss(13'h1234);
    endtask
    task automatic s_uncached;
        for (int i = 0; i < 4; i++) begin
            access(addr_b, 1'b1, 1'b1, i > 1, i < 2);
            expect_pass(1'b1, 13'h0002);
        end
        // nothing was allocated, so a cacheable read still misses
        access(addr_b, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_miss(13'h0567);
    endtask
    task automatic s_local;
        access(addr_a, 1'b0, 1'b1, 1'b1, 1'b1);
        expect_pass(1'b0, 13'h0000);
        access(30'h2000_003e, 1'b1, 1'b0, 1'b1, 1'b1);
        expect_pass(1'b0, 13'h0000);
    endtask
    task automatic s_flush;
        flush = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        repeat (2) begin
            access(addr_a, 1'b1, 1'b1, 1'b1, 1'b1);
            chk_bit("system cycle", 1'b1, saw_sys);
            chk_val("ready cycle", 13'h0002, rc);
        end
        flush = 1'b0;
        repeat (8210) @(negedge ref_clk_i);
        access(addr_a, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_miss(13'h1234);
    endtask
    task automatic s_two_way;
        cfg = 1'b1;
        flush = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        flush = 1'b0;
        repeat (8210) @(negedge ref_clk_i);
        access(addr_a, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_miss(13'h0234);
        access(addr_d, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_miss(13'h0234);
        access(addr_a, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_hit(13'h0234);
        access(addr_d, 1'b1, 1'b1, 1'b1, 1'b1);
        expect_hit(13'h0234);
    endtask
    initial begin
        repeat (6) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        repeat (8210) @(negedge ref_clk_i);
        s_direct();
        s_uncached();
        s_local();
        s_flush();
        s_two_way();
        final_report();
    end
endmodule
